// ==== src/cssd_pkg.sv ====
/*
  Shared constants and carriers for the shift and subtract decode unit:
  opcodes, instruction lengths, cycle counts and the packed structs that
  carry an instruction, the flags and the decoded operand fields.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cssd_pkg;

  // ***********************************************************************
  // Opcodes
  // ***********************************************************************
  localparam logic [7:0] OP_RR_REG    = 8'he0;
  localparam logic [7:0] OP_RR_IND    = 8'he1;
  localparam logic [7:0] OP_RRC_REG   = 8'hc0;
  localparam logic [7:0] OP_RRC_IND   = 8'hc1;
  localparam logic [7:0] OP_SRA_REG   = 8'hd0;
  localparam logic [7:0] OP_SRA_IND   = 8'hd1;
  localparam logic [7:0] OP_PREFIX    = 8'h1f;
  localparam logic [7:0] OP_SBC_FIRST = 8'h32;
  localparam logic [7:0] OP_SBC_LAST  = 8'h37;
  localparam logic [7:0] OP_SUB_FIRST = 8'h22;
  localparam logic [7:0] OP_SUB_LAST  = 8'h27;
  localparam logic [7:0] OP_EXTENDED_BORROW_MINUS_OP_EE   = 8'h38;
  localparam logic [7:0] OP_EXTENDED_BORROW_MINUS_OP_EI   = 8'h39;
  localparam logic [7:0] OP_SET_CARRY = 8'hdf;
  localparam logic [7:0] OP_BANK_LOAD = 8'h01;
  localparam logic [7:0] OP_STOP      = 8'h6f;

  // ***********************************************************************
  // Lengths in bytes and execution cycles
  // ***********************************************************************
  localparam logic [2:0] LEN_ONE   = 3'h1;
  localparam logic [2:0] LEN_TWO   = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR  = 3'h4;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] LAST_CNT  = 3'h1;
  localparam logic [2:0] SUB_SHORT = 3'h3;
  localparam logic [3:0] WREG_HI   = 4'he;

  // ***********************************************************************
  // Carriers
  // ***********************************************************************
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } cssd_instr_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } cssd_flags_t;

  typedef struct packed {
    logic [11:0]       dst_addr;
    logic [11:0]       src_addr;
    logic              dst_ind;
    logic              src_ind;
    logic              src_lit;
    logic [7:0]        literal_value;
    logic signed [7:0] disp;
  } cssd_opnd_t;

endpackage

// ==== src/cssd_core.sv ====
/*
  Decode and execute unit for the right rotates and shifts, subtract,
  subtract with borrow (plain and far-space forms), set carry, working
  bank pointer load and stop entry.
  Assumes the fetch stage presents all instruction bytes together with the
  already resolved destination and source values and the current flags.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: Rotate right E0/E1: 2 bytes, 2 or 3 cycles, bit 0 to C, C Z S V set.
// RULE2: Rotate through carry C0/C1: 2 bytes, 2 or 3 cycles, C Z S V set.
// RULE3: Subtract with borrow 32 to 37 is dst - src - C and sets D to 1.
// RULE4: Far subtract with borrow 38/39: 4 bytes, 3 cycles, same flags.
// RULE5: Set carry DF forces C to 1, keeps other flags, 1 byte, 2 cycles.
// RULE6: Arithmetic shift right D0/D1: bit 0 to C, V cleared, 2 or 3 cycles.
// RULE7: Logical shift right 1F C0/C1: 3 bytes, S cleared, C Z V set.
// RULE8: Opcode 01 loads its literal into the bank pointer, flags kept.
// RULE9: Opcode 6F enters stop mode, one byte, two cycles, all flags kept.
// RULE10: Subtract 22 to 27 is dst - src, sets D to 1, 3 or 4 cycles.
// RULE11: Result flags follow the outcome; unaffected flags keep value.
// RULE12: Working fields 4 bits, register fields 8, displacements signed 8.
// RULE13: Subtract C and H are borrows from bits 7 and 3, V signed overflow.
module cssd_core #(
  parameter int unsigned CNT_W = 3
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  input  wire logic                 in_valid,
  input  wire cssd_pkg::cssd_instr_t instr,
  input  wire logic [7:0]           dst_val,
  input  wire logic [7:0]           src_val,
  input  wire cssd_pkg::cssd_flags_t flags_in,
  output logic                      in_ready,
  output logic                      done,
  output logic [7:0]                res_q,
  output cssd_pkg::cssd_flags_t     flags_q,
  output cssd_pkg::cssd_opnd_t      opnd_q,
  output logic [2:0]                len_q,
  output logic [2:0]                cyc_q,
  output logic                      wr_res_q,
  output logic                      known_q,
  output logic                      stop_q,
  output logic [7:0]                working_bank_pointer_q
);

  // ***********************************************************************
  // Elaboration check
  // ***********************************************************************
  if (CNT_W < 3)
  begin : g_bad_cnt
    $error("CNT_W must hold the longest cycle count");
  end

  // ***********************************************************************
  // Opcode classification
  // ***********************************************************************
  logic [7:0] op;
  logic       pre;
  logic       rotate_right_op;
  logic       rotate_through_carry_op;
  logic       arith_shift_right_op;
  logic       logical_shift_right_op;
  logic       subtract_with_borrow_op;
  logic       subtract_op;
  logic       extended_borrow_minus_op;
  logic       set_carry_op;
  logic       bank_pointer_load_op;
  logic       stop_op;
  logic       shift_any;
  logic       sub_any;
  logic       known;
  logic [7:0] sh_byte;

  // Sort the first byte, or the byte after the prefix, into classes.
  assign op  = instr.b0;
  assign pre = (op == cssd_pkg::OP_PREFIX);
  assign rotate_right_op = (op == cssd_pkg::OP_RR_REG) ||
                           (op == cssd_pkg::OP_RR_IND); // [RULE1]
  assign rotate_through_carry_op = (op == cssd_pkg::OP_RRC_REG) ||
                                   (op == cssd_pkg::OP_RRC_IND); // [RULE2]
  assign arith_shift_right_op = (op == cssd_pkg::OP_SRA_REG) ||
                                (op == cssd_pkg::OP_SRA_IND); // [RULE6]
  assign logical_shift_right_op = pre && // [RULE7]
                                  ((instr.b1 == cssd_pkg::OP_RRC_REG) ||
                                   (instr.b1 == cssd_pkg::OP_RRC_IND));
  assign subtract_with_borrow_op = (op >= cssd_pkg::OP_SBC_FIRST) &&
                                   (op <= cssd_pkg::OP_SBC_LAST); // [RULE3]
  assign subtract_op = (op >= cssd_pkg::OP_SUB_FIRST) &&
                       (op <= cssd_pkg::OP_SUB_LAST); // [RULE10]
  assign extended_borrow_minus_op = (op == cssd_pkg::OP_EXTENDED_BORROW_MINUS_OP_EE) ||
                                    (op == cssd_pkg::OP_EXTENDED_BORROW_MINUS_OP_EI); // [RULE4]
  assign set_carry_op         = (op == cssd_pkg::OP_SET_CARRY); // [RULE5]
  assign bank_pointer_load_op = (op == cssd_pkg::OP_BANK_LOAD); // [RULE8]
  assign stop_op              = (op == cssd_pkg::OP_STOP); // [RULE9]
  assign shift_any = rotate_right_op || rotate_through_carry_op ||
                     arith_shift_right_op || logical_shift_right_op;
  assign sub_any   = subtract_with_borrow_op || subtract_op ||
                     extended_borrow_minus_op;
  assign known     = shift_any || sub_any || set_carry_op ||
                     bank_pointer_load_op || stop_op;
  assign sh_byte   = pre ? instr.b2 : instr.b1;

  // ***********************************************************************
  // Operand field decoding
  // ***********************************************************************
  // A 4-bit working field maps into the bank chosen by the pointer.
  function automatic logic [11:0] wreg(input logic [3:0] n,
                                       input logic [7:0] bp);
    wreg = {bp[3:0], bp[7:4], n};
  endfunction

  // An 8-bit field whose top nibble is E names a working register.
  function automatic logic [11:0] reg8(input logic [7:0] r,
                                       input logic [7:0] bp);
    reg8 = (r[7:4] == cssd_pkg::WREG_HI) ? wreg(r[3:0], bp) : {4'h0, r};
  endfunction

  logic [2:0]          var_sel;
  logic                wpair;
  logic                rpair;
  logic                rlit;
  cssd_pkg::cssd_opnd_t opnd;

  // The low opcode bits pick among the six subtract variants.
  assign var_sel = op[2:0];
  assign wpair   = (sub_any && !extended_borrow_minus_op) &&
                   (var_sel <= cssd_pkg::SUB_SHORT);
  assign rpair   = sub_any && !extended_borrow_minus_op && !wpair &&
                   !var_sel[1];
  assign rlit    = sub_any && !extended_borrow_minus_op && !wpair &&
                   var_sel[1];

  // Address fields for the write-back stage, widths by field kind.
  always_comb
  begin
    opnd               = '0;
    opnd.disp          = $signed(instr.b1); // [RULE12]
    opnd.literal_value = instr.b1;
    if (shift_any)
    begin
      opnd.dst_addr = reg8(sh_byte, working_bank_pointer_q); // [RULE12]
      opnd.dst_ind  = pre ? instr.b1[0] : op[0];
    end
    else if (wpair)
    begin
      opnd.dst_addr = wreg(instr.b1[7:4], working_bank_pointer_q); // [RULE12]
      opnd.src_addr = wreg(instr.b1[3:0], working_bank_pointer_q);
      opnd.src_ind  = var_sel[0];
    end
    else if (rpair)
    begin
      opnd.src_addr = reg8(instr.b1, working_bank_pointer_q); // [RULE12]
      opnd.dst_addr = reg8(instr.b2, working_bank_pointer_q);
      opnd.src_ind  = var_sel[0];
    end
    else if (rlit)
    begin
      opnd.dst_addr      = reg8(instr.b1, working_bank_pointer_q);
      opnd.dst_ind       = var_sel[0];
      opnd.src_lit       = 1'b1;
      opnd.literal_value = instr.b2;
    end
    else if (extended_borrow_minus_op)
    begin
      opnd.dst_addr = {instr.b2[3:0], instr.b3};
      opnd.src_addr = {instr.b1, instr.b2[7:4]};
      opnd.src_lit  = op[0]; // [RULE4]
    end
  end

  // ***********************************************************************
  // Length and cycle count
  // ***********************************************************************
  logic [2:0] len;
  logic [2:0] cyc;

  // Bytes and cycles for each class; indirect forms cost one cycle more.
  assign len = extended_borrow_minus_op ? cssd_pkg::LEN_FOUR :      // [RULE4]
               logical_shift_right_op   ? cssd_pkg::LEN_THREE :     // [RULE7]
               shift_any                ? cssd_pkg::LEN_TWO :       // [RULE1]
               wpair                    ? cssd_pkg::LEN_TWO :
               sub_any                  ? cssd_pkg::LEN_THREE :     // [RULE10]
               bank_pointer_load_op     ? cssd_pkg::LEN_TWO :       // [RULE8]
                                          cssd_pkg::LEN_ONE;        // [RULE5]
  assign cyc = extended_borrow_minus_op ? cssd_pkg::CYC_THREE :     // [RULE4]
               shift_any ? cssd_pkg::CYC_TWO + {2'h0, opnd.dst_ind} :
               sub_any   ? cssd_pkg::CYC_THREE + {2'h0, var_sel[0]} :
                           cssd_pkg::CYC_TWO; // [RULE5] [RULE9]

  // ***********************************************************************
  // Arithmetic and flags
  // ***********************************************************************
  logic [7:0] src_eff;
  logic       bin;
  logic [8:0] diff9;
  logic [4:0] half5;
  logic [7:0] res;
  cssd_pkg::cssd_flags_t nf;

  // Literal forms take the source from the instruction bytes.
  assign src_eff = opnd.src_lit ? opnd.literal_value : src_val;
  assign bin     = (subtract_with_borrow_op || extended_borrow_minus_op) &&
                   flags_in.c; // [RULE3]
  assign diff9   = {1'b0, dst_val} - {1'b0, src_eff} - {8'h00, bin};
  assign half5   = {1'b0, dst_val[3:0]} - {1'b0, src_eff[3:0]} -
                   {4'h0, bin}; // [RULE13]

  // Result and new flags; untouched flags pass through unchanged.
  always_comb
  begin
    nf  = flags_in; // [RULE11]
    res = dst_val;
    if (rotate_right_op)
      res = {dst_val[0], dst_val[7:1]}; // [RULE1]
    else if (rotate_through_carry_op)
      res = {flags_in.c, dst_val[7:1]}; // [RULE2]
    else if (arith_shift_right_op)
      res = {dst_val[7], dst_val[7:1]}; // [RULE6]
    else if (logical_shift_right_op)
      res = {1'b0, dst_val[7:1]}; // [RULE7]
    else if (sub_any)
      res = diff9[7:0];
    if (shift_any)
    begin
      nf.c = dst_val[0];
      nf.z = (res == 8'h00);
      nf.s = res[7];
      nf.v = res[7] ^ dst_val[7];
      if (arith_shift_right_op)
        nf.v = 1'b0; // [RULE6]
    end
    if (sub_any)
    begin
      nf.c = diff9[8]; // [RULE13]
      nf.z = (res == 8'h00);
      nf.s = res[7];
      nf.v = (dst_val[7] ^ src_eff[7]) & (res[7] ^ dst_val[7]); // [RULE13]
      nf.d = 1'b1; // [RULE10]
      nf.h = half5[4]; // [RULE13]
    end
    if (set_carry_op)
      nf.c = 1'b1; // [RULE5]
  end

  // ***********************************************************************
  // Sequencer
  // ***********************************************************************
  typedef enum logic [0:0] {
    CSSD_IDLE = 1'b0,
    CSSD_EXEC = 1'b1
  } cssd_state_t;

  cssd_state_t      st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             fire;
  logic             last;

  // One instruction at a time; done marks the final execution cycle.
  assign in_ready = (st_q == CSSD_IDLE);
  assign fire     = in_valid && in_ready;
  assign last     = (cnt_q == CNT_W'(cssd_pkg::LAST_CNT));
  assign done     = (st_q == CSSD_EXEC) && last;

  // State and cycle counter.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q  <= CSSD_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (st_q)
        CSSD_IDLE:
        begin
          if (fire)
          begin
            st_q  <= CSSD_EXEC;
            cnt_q <= CNT_W'(cyc - cssd_pkg::LAST_CNT);
          end
        end
        CSSD_EXEC:
        begin
          cnt_q <= cnt_q - CNT_W'(cssd_pkg::LAST_CNT);
          if (last)
            st_q <= CSSD_IDLE;
        end
      endcase
    end
  end

  // Results are captured when the instruction is taken.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      res_q    <= '0;
      flags_q  <= '0;
      opnd_q   <= '0;
      len_q    <= '0;
      cyc_q    <= '0;
      wr_res_q <= 1'b0;
      known_q  <= 1'b0;
      stop_q   <= 1'b0;
    end
    else if (fire)
    begin
      res_q    <= res;
      flags_q  <= nf;
      opnd_q   <= opnd;
      len_q    <= len;
      cyc_q    <= cyc;
      wr_res_q <= shift_any || sub_any;
      known_q  <= known;
      stop_q   <= stop_op; // [RULE9]
    end
  end

  // Working bank pointer, loaded from the literal byte.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      working_bank_pointer_q <= '0;
    else if (fire && bank_pointer_load_op)
      working_bank_pointer_q <= instr.b1; // [RULE8]
  end

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_rotate_right_carry : assert property ( // [RULE1]
    fire && rotate_right_op |=> flags_q.c == $past(dst_val[0]) &&
      res_q == {$past(dst_val[0]), $past(dst_val[7:1])} &&
      len_q == cssd_pkg::LEN_TWO && flags_q.d == $past(flags_in.d))
    else $error("rotate right result or carry wrong");
  chk_through_carry_fill : assert property ( // [RULE2]
    fire && rotate_through_carry_op |=> res_q[7] == $past(flags_in.c) &&
      flags_q.c == $past(dst_val[0]))
    else $error("rotate through carry fill wrong");
  chk_borrow_sub_math : assert property ( // [RULE3]
    fire && subtract_with_borrow_op && !opnd.src_lit |=>
      res_q == 8'($past(dst_val) - $past(src_val) -
                  {7'h00, $past(flags_in.c)}) && flags_q.d)
    else $error("subtract with borrow result wrong");
  chk_far_borrow_timing : assert property ( // [RULE4]
    fire && extended_borrow_minus_op |=>
      (!done && len_q == cssd_pkg::LEN_FOUR) ##1 done)
    else $error("far subtract length or timing wrong");
  chk_set_carry_only : assert property ( // [RULE5]
    fire && set_carry_op |=> flags_q.c && done &&
      {flags_q.z, flags_q.s, flags_q.v, flags_q.d, flags_q.h} ==
      $past({flags_in.z, flags_in.s, flags_in.v, flags_in.d, flags_in.h}))
    else $error("set carry flags wrong");
  chk_arith_shift_sign : assert property ( // [RULE6]
    fire && arith_shift_right_op |=> !flags_q.v && res_q[7] == res_q[6])
    else $error("arithmetic shift right wrong");
  chk_logic_shift_sign : assert property ( // [RULE7]
    fire && logical_shift_right_op |=> !flags_q.s && !res_q[7] &&
      len_q == cssd_pkg::LEN_THREE)
    else $error("logical shift right wrong");
  chk_bank_ptr_load : assert property ( // [RULE8]
    fire && bank_pointer_load_op |=>
      working_bank_pointer_q == $past(instr.b1) &&
      flags_q == $past(flags_in))
    else $error("bank pointer load wrong");
  chk_stop_entry : assert property ( // [RULE9]
    fire && stop_op |=> stop_q && done && len_q == cssd_pkg::LEN_ONE)
    else $error("stop entry wrong");
  chk_sub_indirect_cycles : assert property ( // [RULE10]
    fire && subtract_op && op[0] |=> !done ##1 !done ##1 done)
    else $error("subtract indirect cycle count wrong");
  chk_unaffected_keep : assert property ( // [RULE11]
    fire && shift_any |=> flags_q.d == $past(flags_in.d) &&
      flags_q.h == $past(flags_in.h))
    else $error("unaffected flag changed");
  chk_working_field : assert property ( // [RULE12]
    fire && wpair |=> opnd_q.dst_addr[3:0] == $past(instr.b1[7:4]) &&
      opnd_q.src_addr[3:0] == $past(instr.b1[3:0]))
    else $error("working field decode wrong");
  chk_sub_borrow_flag : assert property ( // [RULE13]
    fire && subtract_op && !opnd.src_lit |=>
      flags_q.c == ($past(dst_val) < $past(src_val)))
    else $error("subtract borrow flag wrong");

endmodule

`default_nettype wire

// ==== tb/cssd_core_tb.sv ====
/*
  Self-checking bench for the shift and subtract decode unit: drives
  random instructions of every opcode through the take handshake, notes
  the expected outcome in a queue and compares it when done pulses.
  Assumes the cssd_pkg package and the cssd_core module are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module cssd_core_tb;

  // ***********************************************************************
  // Signals and bookkeeping
  // ***********************************************************************
  typedef struct {
    logic [7:0]            res;
    cssd_pkg::cssd_flags_t flags;
    logic [2:0]            len;
    logic [2:0]            cyc;
    logic                  chk;
    logic                  known;
    logic                  stop;
    logic [7:0]            lit;
    logic                  chklit;
    logic [7:0]            bp;
    time                   t0;
  } cssd_note_t;

  logic                  mclk     = 1'b0;
  logic                  arst_n   = 1'b0;
  logic                  in_valid = 1'b0;
  cssd_pkg::cssd_instr_t instr    = '0;
  logic [7:0]            dst_val  = 8'h00;
  logic [7:0]            src_val  = 8'h00;
  cssd_pkg::cssd_flags_t flags_in = '0;
  logic                  in_ready, done, wr_res_q, known_q, stop_q;
  logic [7:0]            res_q, working_bank_pointer_q;
  cssd_pkg::cssd_flags_t flags_q;
  cssd_pkg::cssd_opnd_t  opnd_q;
  logic [2:0]            len_q, cyc_q;
  int                    mismatches = 0;
  int                    checked    = 0;
  cssd_note_t            notes[$];
  cssd_note_t            mn;
  logic [7:0]            bp_m = 8'h00;

  // Opcode table; a nonzero low byte forces the second instruction byte.
  localparam logic [15:0] OPS [26] = '{
    16'he000, 16'he100, 16'hc000, 16'hc100, 16'hd000, 16'hd100,
    16'h1fc0, 16'h1fc1, 16'h2200, 16'h2300, 16'h2400, 16'h2500,
    16'h2600, 16'h2700, 16'h3200, 16'h3300, 16'h3400, 16'h3500,
    16'h3600, 16'h3700, 16'h3800, 16'h3900, 16'hdf00, 16'h0100,
    16'h6f00, 16'h5500};
  // Operand pairs that hit zero, borrow and signed overflow.
  localparam logic [15:0] EDGE [4] = '{16'h0000, 16'h8001, 16'h0101,
                                       16'h7f80};

  // The clock toggles every half period of 10 ns.
  always #10 mclk = ~mclk;

  cssd_core cssd_core_inst (
    .mclk                   (mclk),
    .arst_n                 (arst_n),
    .in_valid               (in_valid),
    .instr                  (instr),
    .dst_val                (dst_val),
    .src_val                (src_val),
    .flags_in               (flags_in),
    .in_ready               (in_ready),
    .done                   (done),
    .res_q                  (res_q),
    .flags_q                (flags_q),
    .opnd_q                 (opnd_q),
    .len_q                  (len_q),
    .cyc_q                  (cyc_q),
    .wr_res_q               (wr_res_q),
    .known_q                (known_q),
    .stop_q                 (stop_q),
    .working_bank_pointer_q (working_bank_pointer_q)
  );

  // ***********************************************************************
  // Reference model and compare tasks
  // ***********************************************************************
  // Works out result, flags, length and cycle count of one instruction.
  function automatic cssd_note_t model(cssd_pkg::cssd_instr_t i,
                                       logic [7:0] d, logic [7:0] s,
                                       cssd_pkg::cssd_flags_t f);
    cssd_note_t n;
    logic [7:0] op, r, b;
    logic [8:0] w;
    logic [4:0] hn;
    logic       cin, pfx;
    n = '{res: 8'h00, flags: f, len: 3'h2, cyc: 3'h2, chk: 1'b0,
          known: 1'b1, stop: 1'b0, lit: 8'h00, chklit: 1'b0,
          bp: 8'h00, t0: 0};
    pfx = (i.b0 == 8'h1f);
    op  = pfx ? i.b1 : i.b0;
    if (pfx || op inside {8'he0, 8'he1, 8'hc0, 8'hc1, 8'hd0, 8'hd1})
    begin
      r = {(pfx ? 1'b0 : op == 8'he0 || op == 8'he1 ? d[0] :
            op[4] ? d[7] : f.c), d[7:1]};
      n.flags.c = d[0];
      n.flags.z = (r == 8'h00);
      n.flags.s = pfx ? 1'b0 : r[7];
      n.flags.v = (op[7:4] == 4'hd && !pfx) ? 1'b0 : r[7] ^ d[7];
      n.len = pfx ? 3'h3 : 3'h2;
      n.cyc = op[0] ? 3'h3 : 3'h2;
      n.res = r;
      n.chk = 1'b1;
    end
    else if (op inside {[8'h22:8'h27], [8'h32:8'h39]})
    begin
      cin = op[4] & f.c;
      n.chklit = op inside {8'h26, 8'h27, 8'h36, 8'h37, 8'h39};
      n.lit = (op == 8'h39) ? i.b1 : i.b2;
      b  = n.chklit ? n.lit : s;
      w  = {1'b0, d} - {1'b0, b} - {8'h00, cin};
      hn = {1'b0, d[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      r  = w[7:0];
      n.flags = '{c: w[8], z: r == 8'h00, s: r[7], d: 1'b1, h: hn[4],
                  v: (d[7] ^ b[7]) & (d[7] ^ r[7])};
      n.len = op[3] ? 3'h4 : (op[3:1] == 3'h1) ? 3'h2 : 3'h3;
      n.cyc = op[3] ? 3'h3 : op[0] ? 3'h4 : 3'h3;
      n.res = r;
      n.chk = 1'b1;
    end
    else if (op == 8'hdf)
    begin
      n.flags.c = 1'b1;
      n.len = 3'h1;
    end
    else if (op == 8'h6f)
    begin
      n.stop = 1'b1;
      n.len = 3'h1;
    end
    else if (op != 8'h01)
    begin
      n.known = 1'b0;
      n.len = 3'h1;
    end
    return n;
  endfunction

  task automatic miss(string m);
    $display("CHECK FAILED at %0t: %s", $time, m);
    mismatches++;
  endtask

  task automatic cmp8(logic [7:0] a, logic [7:0] e, string m);
    checked++;
    if (a !== e) miss(m);
  endtask

  task automatic cmp3(logic [2:0] a, logic [2:0] e, string m);
    checked++;
    if (a !== e) miss(m);
  endtask

  task automatic cmp1(logic a, logic e, string m);
    checked++;
    if (a !== e) miss(m);
  endtask

  task automatic cmpf(cssd_pkg::cssd_flags_t a, cssd_pkg::cssd_flags_t e);
    checked++;
    if (a !== e) miss("flag vector differs");
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Checks the idle values that reset leaves on the outputs.
  task automatic check_reset();
    cmp8(res_q, 8'h00, "result after reset");
    cmp8(working_bank_pointer_q, 8'h00, "pointer after reset");
    cmp1(stop_q, 1'b0, "stop after reset");
    cmp1(in_ready, 1'b1, "ready after reset");
    cmp1(done, 1'b0, "done after reset");
  endtask

  // ***********************************************************************
  // Driver
  // ***********************************************************************
  // Offers one instruction, then keeps offering junk while busy.
  task automatic issue(int k, int r);
    cssd_pkg::cssd_instr_t i;
    cssd_pkg::cssd_flags_t f;
    logic [7:0]            d, s;
    cssd_note_t            n;
    int                    w;
    i = $urandom;
    i.b0 = OPS[k][15:8];
    if (OPS[k][7:0] != 8'h00) i.b1 = OPS[k][7:0];
    {d, s} = (r < 4) ? EDGE[r] : 16'($urandom);
    f = 6'($urandom);
    @(posedge mclk);
    in_valid <= 1'b1;
    instr    <= i;
    dst_val  <= d;
    src_val  <= s;
    flags_in <= f;
    @(posedge mclk);
    if (i.b0 == 8'h01) bp_m = i.b1;
    n = model(i, d, s, f);
    n.bp = bp_m;
    n.t0 = $time;
    notes.push_back(n);
    instr    <= {8'h55, 24'($urandom)};
    dst_val  <= 8'($urandom);
    flags_in <= 6'($urandom);
    w = 0;
    do
    begin
      @(negedge mclk);
      w++;
    end
    while (done !== 1'b1 && w < 8);
    if (w >= 8) miss("no completion");
  endtask

  // ***********************************************************************
  // Monitor, main sequence and watchdog
  // ***********************************************************************
  // Takes the oldest note whenever done pulses and compares the outputs.
  always @(negedge mclk)
  begin
    if (done === 1'b1)
    begin
      if (notes.size() == 0)
        miss("completion without a request");
      else
      begin
        mn = notes.pop_front();
        if (mn.chk) cmp8(res_q, mn.res, "result");
        cmpf(flags_q, mn.flags);
        cmp3(len_q, mn.len, "length");
        cmp3(cyc_q, mn.cyc, "cycle count");
        cmp8(8'(($time - mn.t0 + 10) / 20), 8'(mn.cyc - 3'h1),
             "timing");
        cmp1(opnd_q.src_lit, mn.chklit, "literal source");
        cmp1(wr_res_q, mn.chk, "result write");
        cmp1(known_q, mn.known, "known opcode");
        cmp1(stop_q, mn.stop, "stop level");
        cmp8(working_bank_pointer_q, mn.bp, "bank pointer");
        if (mn.chklit)
          cmp8(opnd_q.literal_value, mn.lit, "literal field");
      end
    end
  end

  // Resets, then runs every opcode many rounds with a reset midway.
  initial
  begin
    void'($urandom(32'hc9961e84));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    check_reset();
    @(posedge mclk);
    arst_n <= 1'b1;
    for (int r = 0; r < 30; r++)
    begin
      if (r == 15)
      begin
        @(posedge mclk);
        arst_n   <= 1'b0;
        in_valid <= 1'b0;
        bp_m = 8'h00;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check_reset();
        @(posedge mclk);
        arst_n <= 1'b1;
      end
      for (int k = 0; k < 26; k++)
        issue(k, r);
    end
    @(posedge mclk);
    in_valid <= 1'b0;
    repeat (4) @(posedge mclk);
    wrap_up();
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    #400000;
    miss("watchdog expired");
    wrap_up();
  end

endmodule

`default_nettype wire
